// ---- shared/csr_map.vh ----
/*
 * Register map of the charger setpoint bank: byte offsets, field masks,
 * clamp bounds (held in register bit positions) and reset values.
 * Assumes it is included by bare name from the setpoint bank module.
 */
// Contract
// - 16-bit register as low byte, then high byte
// - feedback target bits 4:0, 2 mV, default 10h
// - fast charge 10:2, clamp 8h-190h, reset/watchdog default
// - fast charge limit is lower of register, pin
// - input current 10:2, clamp 8h-190h, default 190h
// - input current limit is lower of register, pin
// - input voltage floor 13:2, clamp D2h-708h
// - tracking sweep uses voltage floor as lower bound
// - reverse current 10:2, clamp 8h-190h, default 190h
// - reverse voltage 13:2, clamp A5h-708h, default FAh
// - precharge 9:2, clamp 5h-C8h, default 50h
// - precharge limit is lower of register, pin
`ifndef CSR_MAP_VH
`define CSR_MAP_VH

// byte offsets of the low byte of each register
`define CSR_OFS_VFB     8'h00
`define CSR_OFS_FCC     8'h02
`define CSR_OFS_IAC     8'h06
`define CSR_OFS_VAC     8'h08
`define CSR_OFS_IREV    8'h0A
`define CSR_OFS_VREV    8'h0C
`define CSR_OFS_IPRE    8'h10

// bank indices
`define CSR_IX_VFB      3'h0
`define CSR_IX_FCC      3'h1
`define CSR_IX_IAC      3'h2
`define CSR_IX_VAC      3'h3
`define CSR_IX_IREV     3'h4
`define CSR_IX_VREV     3'h5
`define CSR_IX_IPRE     3'h6
`define CSR_NREG        7

// field positions
`define CSR_FLD_LSB     2
`define CSR_VFB_MSB     4
`define CSR_CUR_MSB     10
`define CSR_VOLT_MSB    13
`define CSR_PRE_MSB     9

// writable bits of each register
`define CSR_MSK_VFB     16'h001F
`define CSR_MSK_CUR     16'h07FC
`define CSR_MSK_VOLT    16'h3FFC
`define CSR_MSK_PRE     16'h03FC

// clamp bounds, already shifted into bits 15:2
`define CSR_CUR_MIN     16'h0020
`define CSR_CUR_MAX     16'h0640
`define CSR_VAC_MIN     16'h0348
`define CSR_VREV_MIN    16'h0294
`define CSR_VOLT_MAX    16'h1C20
`define CSR_PRE_MIN     16'h0014
`define CSR_PRE_MAX     16'h0320

// reset values
`define CSR_RST_VFB     16'h0010
`define CSR_RST_FCC     16'h0640
`define CSR_RST_IAC     16'h0640
`define CSR_RST_VAC     16'h0348
`define CSR_RST_IREV    16'h0640
`define CSR_RST_VREV    16'h03E8
`define CSR_RST_IPRE    16'h0140

`endif

// ---- core/csr_sync.v ----
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a quasi-static level from outside the clk domain.
 */
`timescale 1ns/1ns
module csr_sync #(
	parameter W = 1
) (
	// system
	input  wire         clk,
	input  wire         rst,
	input  wire         ce,
	// levels
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= {W{1'b0}};
			q    <= {W{1'b0}};
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ---- core/csr_min.v ----
/*
 * Registered lower-of-two selector for current limit codes.
 * Assumes both operands are unsigned codes of the same step size.
 */
`timescale 1ns/1ns
module csr_min #(
	parameter W = 9
) (
	// system
	input  wire         clk,
	input  wire         rst,
	input  wire         ce,
	// operands and result
	input  wire [W-1:0] a,
	input  wire [W-1:0] b,
	output reg  [W-1:0] y
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			y <= {W{1'b0}};
		end else if (ce) begin
			y <= (a < b) ? a : b;
		end
	end
endmodule

// ---- core/csr_setpoint_bank.v ----
/*
 * Setpoint register bank of a buck-boost charge controller, reached
 * through a two-wire serial target port with an 8-bit byte pointer.
 * Assumes scl/sda are resolved open-drain pins and that pin limit codes
 * are slow levels; reset sources come from logic on clk.
 */
`timescale 1ns/1ns
`include "csr_map.vh"
module csr_setpoint_bank #(
	parameter [6:0] DEV_ADDR = 7'h2A
) (
	// system
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	// serial bus pins
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe,
	// reset sources
	input  wire        reg_reset,
	input  wire        watchdog_expire,
	// pin limits and mode
	input  wire [8:0]  charge_current_pin_limit,
	input  wire [8:0]  input_limit_pin,
	input  wire        solar_tracking_enable,
	// setpoints to the regulation loops
	output reg  [4:0]  feedback_voltage_target,
	output wire [8:0]  fast_charge_current_limit,
	output wire [8:0]  input_current_limit,
	output reg  [11:0] input_voltage_floor_setting,
	output reg  [11:0] sweep_window_floor,
	output reg         sweep_window_floor_valid,
	output reg  [8:0]  reverse_output_current_setting,
	output reg  [11:0] reverse_output_voltage_setting,
	output wire [8:0]  precondition_current_limit
);
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_ADDR  = 3'h1;
	localparam [2:0] ST_AACK  = 3'h2;
	localparam [2:0] ST_WR    = 3'h3;
	localparam [2:0] ST_WACK  = 3'h4;
	localparam [2:0] ST_RD    = 3'h5;
	localparam [2:0] ST_RACK  = 3'h6;

	// decoded word index: {valid, index}
	function [3:0] reg_index;
		input [6:0] word;
		begin
			case (word)
			7'h00:   reg_index = {1'b1, `CSR_IX_VFB};
			7'h01:   reg_index = {1'b1, `CSR_IX_FCC};
			7'h03:   reg_index = {1'b1, `CSR_IX_IAC};
			7'h04:   reg_index = {1'b1, `CSR_IX_VAC};
			7'h05:   reg_index = {1'b1, `CSR_IX_IREV};
			7'h06:   reg_index = {1'b1, `CSR_IX_VREV};
			7'h08:   reg_index = {1'b1, `CSR_IX_IPRE};
			default: reg_index = 4'h0;
			endcase
		end
	endfunction

	// mask reserved bits, then clamp the field to its range
	function [15:0] fix;
		input [2:0]  ix;
		input [15:0] w;
		reg   [15:0] msk;
		reg   [15:0] lo;
		reg   [15:0] hi;
		reg   [15:0] m;
		begin
			case (ix)
			`CSR_IX_VFB: begin
				msk = `CSR_MSK_VFB;
				lo  = 16'h0000;
				hi  = `CSR_MSK_VFB;
			end
			`CSR_IX_VAC: begin
				msk = `CSR_MSK_VOLT;
				lo  = `CSR_VAC_MIN;
				hi  = `CSR_VOLT_MAX;
			end
			`CSR_IX_VREV: begin
				msk = `CSR_MSK_VOLT;
				lo  = `CSR_VREV_MIN;
				hi  = `CSR_VOLT_MAX;
			end
			`CSR_IX_IPRE: begin
				msk = `CSR_MSK_PRE;
				lo  = `CSR_PRE_MIN;
				hi  = `CSR_PRE_MAX;
			end
			default: begin
				msk = `CSR_MSK_CUR;
				lo  = `CSR_CUR_MIN;
				hi  = `CSR_CUR_MAX;
			end
			endcase
			m = w & msk;
			if (m < lo)
				fix = lo;
			else if (m > hi)
				fix = hi;
			else
				fix = m;
		end
	endfunction

	wire [8:0]  chg_pin_s;
	wire [8:0]  lim_pin_s;
	wire        scl_s;
	wire        sda_s;
	reg         scl_p;
	reg         sda_p;
	reg  [2:0]  state;
	reg  [3:0]  bitcnt;
	reg  [7:0]  shreg;
	reg  [7:0]  txsh;
	reg  [7:0]  ptr;
	reg         rw;
	reg         first;
	reg         nack;
	reg         pend_v;
	reg  [2:0]  pend_ix;
	reg  [7:0]  pend_lo;
	reg  [15:0] bank [0:`CSR_NREG-1];

	assign sda_out = 1'b0;

	csr_sync #(.W(20)) u_sync (
		.clk(clk), .rst(rst), .ce(ce),
		.d  ({scl_in, sda_in, charge_current_pin_limit,
		      input_limit_pin}),
		.q  ({scl_s, sda_s, chg_pin_s, lim_pin_s}));

	wire        start    = scl_s & scl_p & sda_p & ~sda_s;
	wire        stop     = scl_s & scl_p & ~sda_p & sda_s;
	wire        scl_rise = scl_s & ~scl_p;
	wire        scl_fall = ~scl_s & scl_p;
	wire [3:0]  ptr_dec  = reg_index(ptr[7:1]);
	wire        pvalid   = ptr_dec[3];
	wire [2:0]  pix      = ptr_dec[2:0];
	wire [15:0] pword    = bank[pix];
	wire [15:0] pend_word = fix(pend_ix, {bank[pend_ix][15:8], pend_lo});
	wire        pend_other = pend_v & (pend_ix != pix);
	wire [7:0]  hi_lo    = (pend_v & ~pend_other) ? pend_lo : pword[7:0];
	// even address is bits 7:0, odd address is bits 15:8
	wire [7:0]  rd_byte  = ~pvalid ? 8'h00
	                       : (ptr[0] ? pword[15:8] : pword[7:0]);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_p   <= 1'b0;
			sda_p   <= 1'b0;
			state   <= ST_IDLE;
			bitcnt  <= 4'h0;
			shreg   <= 8'h00;
			txsh    <= 8'h00;
			ptr     <= 8'h00;
			rw      <= 1'b0;
			first   <= 1'b0;
			nack    <= 1'b0;
			sda_oe  <= 1'b0;
			pend_v  <= 1'b0;
			pend_ix <= 3'h0;
			pend_lo <= 8'h00;
			bank[0] <= `CSR_RST_VFB;
			bank[1] <= `CSR_RST_FCC;
			bank[2] <= `CSR_RST_IAC;
			bank[3] <= `CSR_RST_VAC;
			bank[4] <= `CSR_RST_IREV;
			bank[5] <= `CSR_RST_VREV;
			bank[6] <= `CSR_RST_IPRE;
		end else if (ce) begin
			scl_p <= scl_s;
			sda_p <= sda_s;
			if (start || stop) begin
				// a lone low byte takes effect when the transfer ends
				if (pend_v)
					bank[pend_ix] <= pend_word;
				pend_v <= 1'b0;
				sda_oe <= 1'b0;
				bitcnt <= 4'h0;
				state  <= start ? ST_ADDR : ST_IDLE;
			end else if (scl_rise) begin
				case (state)
				ST_ADDR, ST_WR: begin
					shreg  <= {shreg[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end
				ST_RD: begin
					bitcnt <= bitcnt + 4'h1;
				end
				ST_RACK: begin
					nack <= sda_s;
				end
				default: begin
					bitcnt <= bitcnt;
				end
				endcase
			end else if (scl_fall) begin
				case (state)
				ST_ADDR: begin
					if (bitcnt == 4'h8) begin
						if (shreg[7:1] == DEV_ADDR) begin
							rw     <= shreg[0];
							sda_oe <= 1'b1;
							state  <= ST_AACK;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					bitcnt <= 4'h0;
					if (rw) begin
						txsh   <= rd_byte;
						sda_oe <= ~rd_byte[7];
						state  <= ST_RD;
					end else begin
						sda_oe <= 1'b0;
						first  <= 1'b1;
						state  <= ST_WR;
					end
				end
				ST_WR: begin
					if (bitcnt == 4'h8) begin
						sda_oe <= 1'b1;
						state  <= ST_WACK;
						first  <= 1'b0;
						if (first) begin
							ptr <= shreg;
						end else begin
							ptr <= ptr + 8'h01;
							if (pvalid && pend_other)
								bank[pend_ix] <= pend_word;
							if (pvalid && !ptr[0]) begin
								// low byte waits for its high byte
								pend_v  <= 1'b1;
								pend_ix <= pix;
								pend_lo <= shreg;
							end else if (pvalid) begin
								bank[pix] <= fix(pix, {shreg, hi_lo});
								pend_v <= 1'b0;
							end
						end
					end
				end
				ST_WACK: begin
					sda_oe <= 1'b0;
					bitcnt <= 4'h0;
					state  <= ST_WR;
				end
				ST_RD: begin
					if (bitcnt == 4'h8) begin
						sda_oe <= 1'b0;
						ptr    <= ptr + 8'h01;
						state  <= ST_RACK;
					end else begin
						txsh   <= {txsh[6:0], 1'b0};
						sda_oe <= ~txsh[6];
					end
				end
				ST_RACK: begin
					bitcnt <= 4'h0;
					if (nack) begin
						state <= ST_IDLE;
					end else begin
						txsh   <= rd_byte;
						sda_oe <= ~rd_byte[7];
						state  <= ST_RD;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
			// reset sources override a bus write in the same cycle
			if (reg_reset) begin
				bank[0] <= `CSR_RST_VFB;
				bank[1] <= `CSR_RST_FCC;
				bank[2] <= `CSR_RST_IAC;
				bank[3] <= `CSR_RST_VAC;
				bank[4] <= `CSR_RST_IREV;
				bank[5] <= `CSR_RST_VREV;
				bank[6] <= `CSR_RST_IPRE;
				pend_v  <= 1'b0;
			end else if (watchdog_expire) begin
				bank[1] <= `CSR_RST_FCC;
				if (pend_v && pend_ix == `CSR_IX_FCC)
					pend_v <= 1'b0;
			end
		end
	end

	// setpoint outputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			feedback_voltage_target        <= 5'h00;
			input_voltage_floor_setting    <= 12'h000;
			sweep_window_floor             <= 12'h000;
			sweep_window_floor_valid       <= 1'b0;
			reverse_output_current_setting <= 9'h000;
			reverse_output_voltage_setting <= 12'h000;
		end else if (ce) begin
			feedback_voltage_target <= bank[0][`CSR_VFB_MSB:0];
			input_voltage_floor_setting <= bank[3][`CSR_VOLT_MSB:`CSR_FLD_LSB];
			sweep_window_floor <= solar_tracking_enable
				? bank[3][`CSR_VOLT_MSB:`CSR_FLD_LSB]
				: 12'h000;
			sweep_window_floor_valid <= solar_tracking_enable;
			reverse_output_current_setting <= bank[4][`CSR_CUR_MSB:`CSR_FLD_LSB];
			reverse_output_voltage_setting <= bank[5][`CSR_VOLT_MSB:`CSR_FLD_LSB];
		end
	end

	// applied limits: lower of register and pin setting
	csr_min #(.W(9)) u_min_chg (
		.clk(clk), .rst(rst), .ce(ce), .b(chg_pin_s),
		.a  (bank[1][`CSR_CUR_MSB:`CSR_FLD_LSB]),
		.y  (fast_charge_current_limit));

	csr_min #(.W(9)) u_min_iac (
		.clk(clk), .rst(rst), .ce(ce), .b(lim_pin_s),
		.a  (bank[2][`CSR_CUR_MSB:`CSR_FLD_LSB]),
		.y  (input_current_limit));

	csr_min #(.W(9)) u_min_pre (
		.clk(clk), .rst(rst), .ce(ce), .b(chg_pin_s),
		.a  ({1'b0, bank[6][`CSR_PRE_MSB:`CSR_FLD_LSB]}),
		.y  (precondition_current_limit));
endmodule

// ---- sim/csr_host_model.sv ----
/* bus host model: open-drain clock/data master with register tasks.
   assumes the pull-up on the data line lives here. */
`timescale 1ns/1ns
module csr_host_model #(
	parameter [6:0] ADDR = 7'h2A
) (
	// system
	input  wire clk,
	// bus pins
	input  wire sda_oe,
	output reg  scl,
	output wire sda
);
	reg        low;
	reg        b;
	reg  [7:0] q;
	reg  [7:0] nacks;
	// pulled up unless someone pulls low
	assign sda = ~(low | sda_oe);
	initial begin
		scl = 1'b1;
		low = 1'b0;
		nacks = 8'h00;
	end
	task hold;
		repeat (5) @(posedge clk);
	endtask
	// start (or repeated start) when s, else stop
	task cond(input s);
		low <= ~s;
		hold;
		scl <= 1'b1;
		hold;
		low <= s;
		hold;
		if (s)
			scl <= 1'b0;
		hold;
	endtask
	task bit_x(input v, output r);
		low <= ~v;
		hold;
		scl <= 1'b1;
		hold;
		r = sda;
		scl <= 1'b0;
		hold;
	endtask
	// rd: host gives the ack bit (last = nack), else device must ack
	task xbyte(input [7:0] d, input rd, input last, output [7:0] r);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
			bit_x(d[i], r[i]);
		bit_x(rd ? last : 1'b1, b);
		if (!rd && b)
			nacks = nacks + 8'h01;
	endtask
	task wr16(input [7:0] a, input [15:0] v);
		cond(1'b1);
		xbyte({ADDR, 1'b0}, 1'b0, 1'b0, q);
		xbyte(a, 1'b0, 1'b0, q);
		xbyte(v[7:0], 1'b0, 1'b0, q);
		xbyte(v[15:8], 1'b0, 1'b0, q);
		cond(1'b0);
	endtask
	task rd16(input [7:0] a, output [15:0] v);
		cond(1'b1);
		xbyte({ADDR, 1'b0}, 1'b0, 1'b0, q);
		xbyte(a, 1'b0, 1'b0, q);
		cond(1'b1);
		xbyte({ADDR, 1'b1}, 1'b0, 1'b0, q);
		xbyte(8'hFF, 1'b1, 1'b0, v[7:0]);
		xbyte(8'hFF, 1'b1, 1'b1, v[15:8]);
		cond(1'b0);
	endtask
endmodule

// ---- sim/csr_bank_checker.sv ----
/* port assertions on the setpoint bank.
   assumes ce is held high and pins settle between changes. */
`timescale 1ns/1ns
module csr_bank_checker (
	// system
	input wire        clk,
	input wire        rst,
	// controls
	input wire        reg_reset,
	input wire        solar_tracking_enable,
	input wire [8:0]  charge_current_pin_limit,
	input wire [8:0]  input_limit_pin,
	// setpoints
	input wire [4:0]  feedback_voltage_target,
	input wire [8:0]  fast_charge_current_limit,
	input wire [8:0]  input_current_limit,
	input wire [11:0] input_voltage_floor_setting,
	input wire [11:0] sweep_window_floor,
	input wire        sweep_window_floor_valid,
	input wire [8:0]  reverse_output_current_setting,
	input wire [11:0] reverse_output_voltage_setting,
	input wire [8:0]  precondition_current_limit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reg up;
	// outputs carry defaults from the second edge after reset
	always @(posedge clk or posedge rst)
		if (rst)
			up <= 1'b0;
		else
			up <= 1'b1;
	chk_fcc_max: assert property (
		fast_charge_current_limit <= 9'h190) else $error("charge over max");
	chk_fcc_pin: assert property (
		$stable(charge_current_pin_limit) [*5] |->
		fast_charge_current_limit <= charge_current_pin_limit)
		else $error("charge limit above pin");
	chk_iac_pin: assert property (
		$stable(input_limit_pin) [*5] |->
		input_current_limit <= input_limit_pin)
		else $error("input limit above pin");
	chk_vac_range: assert property (
		up |-> input_voltage_floor_setting inside {[12'h0D2:12'h708]})
		else $error("voltage floor out of range");
	chk_vrev_range: assert property (
		up |-> reverse_output_voltage_setting inside {[12'h0A5:12'h708]})
		else $error("reverse voltage out of range");
	chk_ipre_max: assert property (
		precondition_current_limit <= 9'h0C8) else $error("precharge over max");
	chk_sweep_floor: assert property (
		solar_tracking_enable |=> sweep_window_floor_valid &&
		sweep_window_floor == input_voltage_floor_setting)
		else $error("sweep floor not the voltage floor");
	chk_rst_vfb: assert property (
		reg_reset |-> ##2 feedback_voltage_target == 5'h10)
		else $error("feedback target not restored");
	chk_rst_irev: assert property (
		reg_reset |-> ##2 reverse_output_current_setting == 9'h190)
		else $error("reverse current not restored");
	cover property (reg_reset);
	cover property (sweep_window_floor_valid);
	cover property (fast_charge_current_limit < charge_current_pin_limit);
endmodule
bind csr_setpoint_bank csr_bank_checker csr_bank_checker_inst (
	.clk(clk), .rst(rst), .reg_reset(reg_reset),
	.solar_tracking_enable(solar_tracking_enable),
	.charge_current_pin_limit(charge_current_pin_limit),
	.input_limit_pin(input_limit_pin),
	.feedback_voltage_target(feedback_voltage_target),
	.fast_charge_current_limit(fast_charge_current_limit),
	.input_current_limit(input_current_limit),
	.input_voltage_floor_setting(input_voltage_floor_setting),
	.sweep_window_floor(sweep_window_floor),
	.sweep_window_floor_valid(sweep_window_floor_valid),
	.reverse_output_current_setting(reverse_output_current_setting),
	.reverse_output_voltage_setting(reverse_output_voltage_setting),
	.precondition_current_limit(precondition_current_limit));

// ---- sim/csr_setpoint_bank_bench.sv ----
/* self-checking bench of the setpoint bank over its serial port.
   assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ns
module csr_setpoint_bank_bench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         reg_reset = 1'b0;
	reg         watchdog_expire = 1'b0;
	reg         trk = 1'b0;
	reg  [8:0]  chg_pin = 9'h1FF;
	reg  [8:0]  lim_pin = 9'h1FF;
	wire        scl, sda, sda_oe, swv;
	wire [4:0]  vfb;
	wire [8:0]  fcc, iac, irev, ipre;
	wire [11:0] vac, swf, vrev;
	reg  [15:0] rd;
	reg  [55:0] r;
	integer     miscompares = 0, n_compared = 0, cycles = 0, i;
	always #10 clk = ~clk;
	csr_host_model csr_host_model_inst (.clk(clk), .sda_oe(sda_oe),
		.scl(scl), .sda(sda));
	csr_setpoint_bank csr_setpoint_bank_inst (.clk(clk), .rst(rst),
		.ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.reg_reset(reg_reset), .watchdog_expire(watchdog_expire),
		.charge_current_pin_limit(chg_pin), .input_limit_pin(lim_pin),
		.solar_tracking_enable(trk), .feedback_voltage_target(vfb),
		.fast_charge_current_limit(fcc), .input_current_limit(iac),
		.input_voltage_floor_setting(vac), .sweep_window_floor(swf),
		.sweep_window_floor_valid(swv),
		.reverse_output_current_setting(irev),
		.reverse_output_voltage_setting(vrev),
		.precondition_current_limit(ipre));
	// offset, reset value, value after all ones, value after all zeros
	function [55:0] row(input [2:0] k);
		case (k)
		3'h0: row = {8'h00, 16'h0010, 16'h001F, 16'h0000};
		3'h1: row = {8'h02, 16'h0640, 16'h0640, 16'h0020};
		3'h2: row = {8'h06, 16'h0640, 16'h0640, 16'h0020};
		3'h3: row = {8'h08, 16'h0348, 16'h1C20, 16'h0348};
		3'h4: row = {8'h0A, 16'h0640, 16'h0640, 16'h0020};
		3'h5: row = {8'h0C, 16'h03E8, 16'h1C20, 16'h0294};
		3'h6: row = {8'h10, 16'h0140, 16'h0320, 16'h0014};
		default: row = {8'h04, 16'h0000, 16'h0000, 16'h0000};
		endcase
	endfunction
	task chk(input [15:0] seen, input [15:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task pulse(input w);
		if (w)
			watchdog_expire <= 1'b1;
		else
			reg_reset <= 1'b1;
		@(posedge clk);
		watchdog_expire <= 1'b0;
		reg_reset <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: run did not finish", $time);
			give_verdict;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		for (i = 0; i < 8; i = i + 1) begin
			r = row(i[2:0]);
			csr_host_model_inst.rd16(r[55:48], rd);
			chk(rd, r[47:32]);
			csr_host_model_inst.wr16(r[55:48], 16'hFFFF);
			csr_host_model_inst.rd16(r[55:48], rd);
			chk(rd, r[31:16]);
			csr_host_model_inst.wr16(r[55:48], 16'h0000);
			csr_host_model_inst.rd16(r[55:48], rd);
			chk(rd, r[15:0]);
		end
		csr_host_model_inst.wr16(8'h02, 16'h0100);
		csr_host_model_inst.wr16(8'h06, 16'h0100);
		csr_host_model_inst.wr16(8'h08, 16'h1000);
		csr_host_model_inst.wr16(8'h10, 16'h0200);
		chk({7'h00, fcc}, 16'h0040);
		chk({7'h00, iac}, 16'h0040);
		chk({7'h00, ipre}, 16'h0080);
		chk({4'h0, vac}, 16'h0400);
		chk({7'h00, irev}, 16'h0008);
		chk({4'h0, vrev}, 16'h00A5);
		chg_pin <= 9'h030;
		lim_pin <= 9'h030;
		trk <= 1'b1;
		repeat (8) @(posedge clk);
		chk({7'h00, fcc}, 16'h0030);
		chk({7'h00, iac}, 16'h0030);
		chk({7'h00, ipre}, 16'h0030);
		chk({3'h0, swv, swf}, 16'h1400);
		pulse(1'b1);
		csr_host_model_inst.rd16(8'h02, rd);
		chk(rd, 16'h0640);
		csr_host_model_inst.rd16(8'h06, rd);
		chk(rd, 16'h0100);
		pulse(1'b0);
		csr_host_model_inst.rd16(8'h08, rd);
		chk(rd, 16'h0348);
		chk({11'h000, vfb}, 16'h0010);
		chk({7'h00, irev}, 16'h0190);
		chk({8'h00, csr_host_model_inst.nacks}, 16'h0000);
		give_verdict;
	end
endmodule
